// ---- rtl/dpm_pkg.sv ----
// Purpose: Shared constants and types for the DS1 path monitor and loopback block
// Assumes: 100 MHz clock; levels are loss below nominal in half-dB units
// Notes: Option word layout is shared by the remote and craft sources
package dpm_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
    localparam int LOS_MS = 150;
    localparam int MS_PER_MIN = 60_000;
    localparam int TO_MIN_0 = 20;
    localparam int TO_MIN_1 = 60;
    localparam int TO_MIN_2 = 120;
    localparam int TO_MIN_3 = 1440;
    localparam int TO_W = 27;
    localparam int LVL_W = 8;
    localparam int ATT_W = 6;
    localparam logic [ATT_W-1:0] LBO_STEP = 6'h0f;
    localparam logic [ATT_W-1:0] AUTO_15 = 6'h1e;
    localparam logic [ATT_W-1:0] AUTO_22P5 = 6'h2d;
    localparam logic [ATT_W-1:0] LBO_HYST = 6'h02;
    localparam int OPT_W = 10;
    localparam int OPT_DS_REGEN = 0;
    localparam int OPT_US_REGEN = 1;
    localparam int OPT_LBO_LO = 2;
    localparam int OPT_LBO_HI = 4;
    localparam int OPT_LINE_B8ZS = 5;
    localparam int OPT_FRAME_ESF = 6;
    localparam int OPT_TO_EN = 7;
    localparam int OPT_TO_LO = 8;
    localparam int OPT_TO_HI = 9;
    localparam logic [OPT_W-1:0] OPT_RESET = 10'h000;
    typedef enum logic [1:0] {LOOP_NONE = 2'b00, LOOP_FAC = 2'b01, LOOP_DUAL = 2'b11,
        LOOP_CUST = 2'b10} dpm_loop_t;
    typedef enum logic [1:0] {LED_OFF = 2'b00, LED_GREEN = 2'b01, LED_RED = 2'b10,
        LED_FLASH_GREEN = 2'b11} dpm_led_t;
    typedef enum logic [1:0] {TX_THRU = 2'b00, TX_LOOP = 2'b01, TX_AIS = 2'b10} dpm_tx_t;
    typedef enum logic [2:0] {LBO_0 = 3'h0, LBO_7P5 = 3'h1, LBO_15 = 3'h2, LBO_22P5 = 3'h3,
        LBO_AUTO_15 = 3'h4, LBO_AUTO_22P5 = 3'h5} dpm_lbo_t;
endpackage

// ---- rtl/dpm_path_ctrl.sv ----
// Purpose: Loss-of-signal timing, option hold, loopback routing, indicators and monitor events
// Assumes: Level-low pins are asynchronous; all other inputs are on clk
// Notes: Index 0 is the facility path, index 1 the customer path
`timescale 1ns/100ps
`default_nettype none
module dpm_path_ctrl
    import dpm_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic facility_level_low,
    input wire logic customer_level_low,
    input wire logic [LVL_W-1:0] facility_level,
    input wire logic [LVL_W-1:0] customer_level,
    input wire logic remote_opt_we,
    input wire logic [OPT_W-1:0] remote_opt_word,
    input wire logic craft_opt_we,
    input wire logic [OPT_W-1:0] craft_opt_word,
    input wire logic code_loop_up,
    input wire logic code_loop_down,
    input wire logic craft_fac_loop,
    input wire logic craft_cust_loop,
    input wire logic craft_dual_loop,
    input wire logic craft_release,
    input wire logic manual_loop_fac,
    input wire logic manual_loop_dual,
    input wire logic manual_release,
    input wire logic zeros8_seen,
    input wire logic zeros16_seen,
    input wire logic b8zs_octet_seen,
    input wire logic sf_fbit_err,
    input wire logic esf_fbit_err,
    input wire logic esf_crc_err,
    input wire logic esf_received,
    output logic facility_los,
    output logic customer_los,
    output logic downstream_regeneration,
    output logic upstream_regeneration,
    output logic [ATT_W-1:0] line_build_out,
    output dpm_tx_t facility_transmit_select,
    output dpm_tx_t customer_transmit_select,
    output dpm_led_t facility_indicator,
    output dpm_led_t customer_indicator,
    output dpm_led_t loopback_indicator,
    output logic loop_timer_running,
    output logic line_err_event,
    output logic b8zs_err_event,
    output logic frame_err_event,
    output logic sef_event,
    output logic nprm_insert
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int LOS_W = 8;
    // Level-low pins synchronised
    logic [1:0] low_meta;
    logic [1:0] low_s;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick_cnt;
    logic ms_tick;
    logic next_ms_tick;
    always_comb begin
        next_ms_tick = 1'b0;
        next_tick_cnt = tick_cnt + 1'b1;
        if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_ms_tick = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_meta <= 2'h0;
            low_s <= 2'h0;
            tick_cnt <= '0;
            ms_tick <= 1'b0;
        end else begin
            low_meta <= {customer_level_low, facility_level_low};
            low_s <= low_meta;
            tick_cnt <= next_tick_cnt;
            ms_tick <= next_ms_tick;
        end
    end

    // Loss qualification per path
    logic [LOS_W-1:0] los_cnt [2];
    logic [LOS_W-1:0] next_los_cnt [2];
    logic [1:0] los;
    logic [1:0] next_los;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_los_cnt[i] = los_cnt[i];
            next_los[i] = los[i];
            if (!low_s[i]) begin
                next_los_cnt[i] = '0;
                next_los[i] = 1'b0;
            end else if (ms_tick && los_cnt[i] != LOS_W'(LOS_MS)) begin
                next_los_cnt[i] = los_cnt[i] + 1'b1;
                next_los[i] = (los_cnt[i] == LOS_W'(LOS_MS - 1));
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            los_cnt[0] <= '0;
            los_cnt[1] <= '0;
            los <= 2'h0;
        end else begin
            los_cnt[0] <= next_los_cnt[0];
            los_cnt[1] <= next_los_cnt[1];
            los <= next_los;
        end
    end

    // Option word; remote wins a same-cycle collision
    logic [OPT_W-1:0] opt;
    logic [OPT_W-1:0] next_opt;
    dpm_lbo_t lbo_mode;
    logic [1:0] to_sel;
    always_comb begin
        next_opt = opt;
        if (remote_opt_we) begin
            next_opt = remote_opt_word;
        end else if (craft_opt_we) begin
            next_opt = craft_opt_word;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            opt <= OPT_RESET;
        end else begin
            opt <= next_opt;
        end
    end
    assign lbo_mode = dpm_lbo_t'(opt[OPT_LBO_HI:OPT_LBO_LO]);
    assign to_sel = opt[OPT_TO_HI:OPT_TO_LO];
    // Loopback state and timeout
    dpm_loop_t loop_state;
    dpm_loop_t next_loop_state;
    logic [TO_W-1:0] to_ms;
    logic [TO_W-1:0] next_to_ms;
    logic [TO_W-1:0] to_limit;
    logic to_expire;
    always_comb begin
        case (to_sel)
            2'h0: to_limit = TO_W'(TO_MIN_0 * MS_PER_MIN);
            2'h1: to_limit = TO_W'(TO_MIN_1 * MS_PER_MIN);
            2'h2: to_limit = TO_W'(TO_MIN_2 * MS_PER_MIN);
            default: to_limit = TO_W'(TO_MIN_3 * MS_PER_MIN);
        endcase
    end
    assign to_expire = opt[OPT_TO_EN] && loop_state != LOOP_NONE && to_ms >= to_limit;
    always_comb begin
        next_loop_state = loop_state;
        if (manual_release || craft_release || code_loop_down || to_expire) begin
            next_loop_state = LOOP_NONE;
        end else if (craft_dual_loop || manual_loop_dual) begin
            next_loop_state = LOOP_DUAL;
        end else if (craft_cust_loop) begin
            next_loop_state = LOOP_CUST;
        end else if (manual_loop_fac || craft_fac_loop) begin
            next_loop_state = LOOP_FAC;
        end else if (code_loop_up) begin
            case (loop_state)
                LOOP_NONE: next_loop_state = LOOP_FAC;
                LOOP_FAC: next_loop_state = LOOP_DUAL;
                default: next_loop_state = loop_state;
            endcase
        end
        next_to_ms = to_ms;
        if (next_loop_state == LOOP_NONE || loop_state == LOOP_NONE) begin
            next_to_ms = '0;
        end else if (ms_tick && opt[OPT_TO_EN]) begin
            next_to_ms = to_ms + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loop_state <= LOOP_NONE;
            to_ms <= '0;
        end else begin
            loop_state <= next_loop_state;
            to_ms <= next_to_ms;
        end
    end
    // Build-out: fixed steps or auto level guard
    logic [ATT_W-1:0] next_lbo;
    logic signed [LVL_W+2:0] need;
    logic [ATT_W-1:0] target;
    logic [ATT_W-1:0] need_att;
    logic [ATT_W-1:0] diff;
    always_comb begin
        target = (lbo_mode == LBO_AUTO_15) ? AUTO_15 : AUTO_22P5;
        need = $signed({5'h00, target}) + $signed({3'h0, facility_level})
            - $signed({3'h0, customer_level});
        if (need < 0) begin
            need_att = '0;
        end else if (need > $signed({5'h00, target})) begin
            need_att = target;
        end else begin
            need_att = ATT_W'(need);
        end
        diff = (need_att > line_build_out) ? need_att - line_build_out : line_build_out - need_att;
        next_lbo = line_build_out;
        case (lbo_mode)
            LBO_0, LBO_7P5, LBO_15, LBO_22P5: next_lbo = ATT_W'(lbo_mode * LBO_STEP);
            LBO_AUTO_15, LBO_AUTO_22P5: begin
                if (diff > LBO_HYST) begin
                    next_lbo = need_att;
                end
            end
            default: next_lbo = '0;
        endcase
    end

    // Routing and indicators, from loop_state and the los flags
    dpm_tx_t next_fac_tx;
    dpm_tx_t next_cust_tx;
    dpm_led_t next_fac_led;
    dpm_led_t next_cust_led;
    dpm_led_t next_lb_led;
    always_comb begin
        next_fac_tx = TX_THRU;
        next_cust_tx = TX_THRU;
        next_fac_led = LED_GREEN;
        next_cust_led = LED_GREEN;
        next_lb_led = (loop_state != LOOP_NONE) ? LED_GREEN : LED_OFF;
        if (loop_state == LOOP_FAC || loop_state == LOOP_DUAL) begin
            next_fac_tx = TX_LOOP;
            next_fac_led = LED_FLASH_GREEN;
        end
        if (loop_state == LOOP_CUST || loop_state == LOOP_DUAL) begin
            next_cust_tx = TX_LOOP;
            next_cust_led = LED_FLASH_GREEN;
        end else if (loop_state == LOOP_FAC || los[0]) begin
            next_cust_tx = TX_AIS;
        end
        if (los[0]) begin
            next_fac_led = LED_RED;
        end
        if (los[1]) begin
            next_cust_led = LED_RED;
        end
    end

    // Monitor events; the line code never reaches routing
    logic next_line_err;
    logic next_b8zs_err;
    logic next_frame_err;
    logic next_sef;
    logic b8zs_mode;
    logic esf_mode;
    always_comb begin
        b8zs_mode = opt[OPT_LINE_B8ZS];
        esf_mode = opt[OPT_FRAME_ESF];
        next_line_err = b8zs_mode && zeros8_seen;
        next_b8zs_err = !b8zs_mode && b8zs_octet_seen;
        next_frame_err = esf_mode ? (esf_fbit_err || esf_crc_err) : sf_fbit_err;
        next_sef = !esf_mode && esf_received;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            facility_los <= 1'b0;
            customer_los <= 1'b0;
            downstream_regeneration <= 1'b0;
            upstream_regeneration <= 1'b0;
            line_build_out <= '0;
            facility_transmit_select <= TX_THRU;
            customer_transmit_select <= TX_THRU;
            facility_indicator <= LED_OFF;
            customer_indicator <= LED_OFF;
            loopback_indicator <= LED_OFF;
            loop_timer_running <= 1'b0;
            line_err_event <= 1'b0;
            b8zs_err_event <= 1'b0;
            frame_err_event <= 1'b0;
            sef_event <= 1'b0;
            nprm_insert <= 1'b0;
        end else begin
            facility_los <= los[0];
            customer_los <= los[1];
            downstream_regeneration <= opt[OPT_DS_REGEN];
            upstream_regeneration <= opt[OPT_US_REGEN];
            line_build_out <= next_lbo;
            facility_transmit_select <= next_fac_tx;
            customer_transmit_select <= next_cust_tx;
            facility_indicator <= next_fac_led;
            customer_indicator <= next_cust_led;
            loopback_indicator <= next_lb_led;
            loop_timer_running <= opt[OPT_TO_EN] && loop_state != LOOP_NONE;
            line_err_event <= next_line_err;
            b8zs_err_event <= next_b8zs_err;
            frame_err_event <= next_frame_err;
            sef_event <= next_sef;
            nprm_insert <= esf_received;
        end
    end
    sequence fac_loop_s;
        loop_state == LOOP_FAC;
    endsequence
    sequence fac_loop_out_s;
        ##1 facility_transmit_select == TX_LOOP && customer_transmit_select == TX_AIS
            && facility_indicator inside {LED_FLASH_GREEN, LED_RED};
    endsequence
    los_fac_red_a: assert property (@(posedge clk) disable iff (!reset_n)
        los[0] |-> ##1 facility_indicator == LED_RED && customer_transmit_select != TX_THRU)
        else $error("facility loss without red indicator or AIS");
    los_cust_red_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(los[1]) |-> los_cnt[1] == LOS_W'(LOS_MS) ##1 customer_indicator == LED_RED)
        else $error("customer loss timing or indicator wrong");
    regen_opt_a: assert property (@(posedge clk) disable iff (!reset_n)
        remote_opt_we |-> ##2 downstream_regeneration == $past(remote_opt_word[OPT_DS_REGEN], 2))
        else $error("downstream regeneration does not follow option");
    lbo_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
        lbo_mode == LBO_15 |-> ##1 line_build_out == AUTO_15)
        else $error("fixed build-out step wrong");
    lbo_hyst_a: assert property (@(posedge clk) disable iff (!reset_n)
        lbo_mode == LBO_AUTO_22P5 && diff <= LBO_HYST |=> $stable(line_build_out))
        else $error("auto build-out moved inside hysteresis");
    ami_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        !b8zs_mode && zeros16_seen && !zeros8_seen |-> ##1 !line_err_event)
        else $error("zero run counted in AMI mode");
    b8zs_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        b8zs_mode |-> ##1 !b8zs_err_event && line_err_event == $past(zeros8_seen))
        else $error("B8ZS mode event mismatch");
    esf_check_a: assert property (@(posedge clk) disable iff (!reset_n)
        esf_mode && esf_crc_err |-> ##1 frame_err_event)
        else $error("CRC error not reported in ESF mode");
    sef_report_a: assert property (@(posedge clk) disable iff (!reset_n)
        !esf_mode && esf_received |-> ##1 sef_event && nprm_insert)
        else $error("SF mismatch not reported or NPRM missing");
    lb_led_a: assert property (@(posedge clk) disable iff (!reset_n)
        loop_state != LOOP_NONE |-> ##1 loopback_indicator == LED_GREEN)
        else $error("loopback indicator off during loopback");
    fac_loop_a: assert property (@(posedge clk) disable iff (!reset_n)
        fac_loop_s |-> fac_loop_out_s)
        else $error("facility loopback routing wrong");
    dual_loop_a: assert property (@(posedge clk) disable iff (!reset_n)
        loop_state == LOOP_DUAL |-> ##1 facility_transmit_select == TX_LOOP
            && customer_transmit_select == TX_LOOP)
        else $error("dual loopback routing wrong");
    timeout_rel_a: assert property (@(posedge clk) disable iff (!reset_n)
        to_expire |=> loop_state == LOOP_NONE)
        else $error("timeout did not release loopback");
    los_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        !low_s[0] |=> los_cnt[0] == '0 && !los[0])
        else $error("loss timer did not restart");
endmodule
`default_nettype wire

// ---- test/dpm_line_model.sv ----
// Purpose: Far-side line model feeding loss pins and measured levels
// Assumes: Loss pins come from a recovered line, so they move off the clock grid
// Notes: Driven through its tasks by the bench
`timescale 1ns/100ps
`default_nettype none
module dpm_line_model
    import dpm_pkg::*;
(
    input wire logic clk,
    output logic facility_level_low,
    output logic customer_level_low,
    output logic [LVL_W-1:0] facility_level,
    output logic [LVL_W-1:0] customer_level
);
    initial begin
        facility_level_low = 1'b0;
        customer_level_low = 1'b0;
        facility_level = 8'h00;
        customer_level = 8'h00;
    end

    // Asynchronous change, a few ns after an edge
    task automatic set_low(input int path, input logic v);
        @(posedge clk);
        #3;
        if (path == 0) begin
            facility_level_low = v;
        end else begin
            customer_level_low = v;
        end
    endtask

    task automatic dropout(input int path, input int cycles);
        set_low(path, 1'b1);
        repeat (cycles) @(posedge clk);
        set_low(path, 1'b0);
    endtask

    task automatic set_level(input logic [LVL_W-1:0] f, input logic [LVL_W-1:0] c);
        @(negedge clk);
        facility_level = f;
        customer_level = c;
    endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the DS1 path monitor and loopback block
// Assumes: Short millisecond tick so loss timing runs in a few hundred cycles
// Notes: Loop and monitor cases run from tables, loss and build-out by hand
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dpm_pkg::*;
    localparam int TICK = 4;
    localparam logic [10:0] E_NONE = {1'b0, TX_THRU, TX_THRU, LED_GREEN, LED_GREEN, LED_OFF};
    localparam logic [10:0] E_FAC = {1'b1, TX_LOOP, TX_AIS, LED_FLASH_GREEN, LED_GREEN, LED_GREEN};
    localparam logic [10:0] E_CUST = {1'b1, TX_THRU, TX_LOOP, LED_GREEN, LED_FLASH_GREEN, LED_GREEN};
    localparam logic [10:0] E_DUAL = {1'b1, TX_LOOP, TX_LOOP, LED_FLASH_GREEN, LED_FLASH_GREEN, LED_GREEN};
    // Command bits: code up, code down, craft fac/cust/dual/release, manual fac/dual/release
    localparam logic [19:0] loops [13] = '{{9'h040, E_FAC}, {9'h008, E_NONE}, {9'h020, E_CUST},
        {9'h100, E_CUST}, {9'h080, E_NONE}, {9'h100, E_FAC}, {9'h100, E_DUAL}, {9'h001, E_NONE},
        {9'h002, E_DUAL}, {9'h008, E_NONE}, {9'h004, E_FAC}, {9'h010, E_DUAL}, {9'h008, E_NONE}};
    // Option word, monitor input index, expected {nprm, sef, frame, b8zs, line}
    localparam logic [17:0] mons [10] = '{{10'h000, 3'h6, 5'h00}, {10'h000, 3'h5, 5'h00},
        {10'h000, 3'h4, 5'h02}, {10'h000, 3'h3, 5'h04}, {10'h000, 3'h0, 5'h18}, {10'h060, 3'h6, 5'h01},
        {10'h060, 3'h4, 5'h00}, {10'h060, 3'h2, 5'h04}, {10'h060, 3'h1, 5'h04}, {10'h060, 3'h0, 5'h10}};
    logic clk, reset_n;
    logic facility_level_low, customer_level_low;
    logic [LVL_W-1:0] facility_level, customer_level;
    logic remote_opt_we, craft_opt_we;
    logic [OPT_W-1:0] remote_opt_word, craft_opt_word;
    logic code_loop_up, code_loop_down, craft_fac_loop, craft_cust_loop, craft_dual_loop, craft_release;
    logic manual_loop_fac, manual_loop_dual, manual_release;
    logic zeros8_seen, zeros16_seen, b8zs_octet_seen, sf_fbit_err, esf_fbit_err, esf_crc_err, esf_received;
    logic facility_los, customer_los, downstream_regeneration, upstream_regeneration;
    logic [ATT_W-1:0] line_build_out;
    dpm_tx_t facility_transmit_select, customer_transmit_select;
    dpm_led_t facility_indicator, customer_indicator, loopback_indicator;
    logic loop_timer_running, line_err_event, b8zs_err_event, frame_err_event, sef_event, nprm_insert;
    logic [8:0] cmd;
    logic [6:0] mon;
    logic [6:0] seen;
    int fails, checked, n;

    assign {code_loop_up, code_loop_down, craft_fac_loop, craft_cust_loop, craft_dual_loop, craft_release,
        manual_loop_fac, manual_loop_dual, manual_release} = cmd;
    assign {zeros8_seen, zeros16_seen, b8zs_octet_seen, sf_fbit_err, esf_fbit_err, esf_crc_err, esf_received} = mon;

    dpm_line_model u_dpm_line_model (.clk(clk), .facility_level_low(facility_level_low),
        .customer_level_low(customer_level_low), .facility_level(facility_level), .customer_level(customer_level));

    dpm_path_ctrl #(.TICK_CYCLES(TICK)) u_dpm_path_ctrl (.clk(clk), .reset_n(reset_n),
        .facility_level_low(facility_level_low), .customer_level_low(customer_level_low),
        .facility_level(facility_level), .customer_level(customer_level), .remote_opt_we(remote_opt_we),
        .remote_opt_word(remote_opt_word), .craft_opt_we(craft_opt_we), .craft_opt_word(craft_opt_word),
        .code_loop_up(code_loop_up), .code_loop_down(code_loop_down), .craft_fac_loop(craft_fac_loop),
        .craft_cust_loop(craft_cust_loop), .craft_dual_loop(craft_dual_loop), .craft_release(craft_release),
        .manual_loop_fac(manual_loop_fac), .manual_loop_dual(manual_loop_dual), .manual_release(manual_release),
        .zeros8_seen(zeros8_seen), .zeros16_seen(zeros16_seen), .b8zs_octet_seen(b8zs_octet_seen),
        .sf_fbit_err(sf_fbit_err), .esf_fbit_err(esf_fbit_err), .esf_crc_err(esf_crc_err),
        .esf_received(esf_received), .facility_los(facility_los), .customer_los(customer_los),
        .downstream_regeneration(downstream_regeneration), .upstream_regeneration(upstream_regeneration),
        .line_build_out(line_build_out), .facility_transmit_select(facility_transmit_select),
        .customer_transmit_select(customer_transmit_select), .facility_indicator(facility_indicator),
        .customer_indicator(customer_indicator), .loopback_indicator(loopback_indicator),
        .loop_timer_running(loop_timer_running), .line_err_event(line_err_event), .b8zs_err_event(b8zs_err_event),
        .frame_err_event(frame_err_event), .sef_event(sef_event), .nprm_insert(nprm_insert));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Sticky capture of pulses and loss flags
    always @(posedge clk) begin
        seen <= seen | {customer_los, facility_los, nprm_insert, sef_event, frame_err_event, b8zs_err_event,
            line_err_event};
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic opt_write(input logic r, input logic c, input logic [OPT_W-1:0] rw, input logic [OPT_W-1:0] cw);
        @(negedge clk);
        remote_opt_we = r;
        craft_opt_we = c;
        remote_opt_word = rw;
        craft_opt_word = cw;
        @(negedge clk);
        remote_opt_we = 1'b0;
        craft_opt_we = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic loop_cmd(input logic [8:0] c);
        @(negedge clk);
        cmd = c;
        @(negedge clk);
        cmd = 9'h000;
        repeat (3) @(negedge clk);
    endtask

    task automatic wait_los(input int path);
        n = 0;
        while ((path == 0 ? facility_los : customer_los) !== 1'b1 && n < 200 * TICK) begin
            @(negedge clk);
            n++;
        end
        check({15'h0000, n >= 149 * TICK && n <= 153 * TICK}, 16'h0001, "loss qualification time");
        repeat (2) @(negedge clk);
    endtask

    task close_out;
        $display("Checks: %0d, mismatches: %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        cmd = 9'h000;
        mon = 7'h00;
        seen = 7'h00;
        remote_opt_we = 1'b0;
        craft_opt_we = 1'b0;
        remote_opt_word = 10'h000;
        craft_opt_word = 10'h000;
        fails = 0;
        checked = 0;
        repeat (12) @(negedge clk);
        check({facility_indicator, loopback_indicator, facility_transmit_select, line_build_out}, 16'h0000,
            "outputs in reset");
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        check({facility_indicator, customer_indicator}, {LED_GREEN, LED_GREEN}, "idle indicators");
        opt_write(1'b1, 1'b0, 10'h00b, 10'h000);
        check({downstream_regeneration, upstream_regeneration, line_build_out}, {2'b11, 6'h1e}, "remote load");
        for (int m = 0; m < 4; m++) begin
            opt_write(1'b0, 1'b1, 10'h000, OPT_W'(m << OPT_LBO_LO));
            check({upstream_regeneration, line_build_out}, {1'b0, 6'(m * 15)}, "fixed build-out");
        end
        opt_write(1'b1, 1'b1, 10'h000, 10'h001);
        check(downstream_regeneration, 1'b0, "remote over craft");
        u_dpm_line_model.set_level(8'h00, 8'h00);
        opt_write(1'b1, 1'b0, 10'h010, 10'h000);
        check(line_build_out, 6'h1e, "auto 15 hot customer");
        u_dpm_line_model.set_level(8'h00, 8'h2d);
        opt_write(1'b1, 1'b0, 10'h014, 10'h000);
        check(line_build_out, 6'h00, "auto 22.5 no loss");
        u_dpm_line_model.set_level(8'h00, 8'h1e);
        repeat (6) @(negedge clk);
        check(line_build_out, 6'h0f, "auto 22.5 adds 7.5 dB");
        u_dpm_line_model.set_level(8'h00, 8'h1d);
        repeat (6) @(negedge clk);
        check(line_build_out, 6'h0f, "hysteresis holds");
        u_dpm_line_model.set_level(8'h00, 8'h1a);
        repeat (6) @(negedge clk);
        check(line_build_out, 6'h13, "auto follows");
        // Unused build-out code falls back to no loss
        opt_write(1'b1, 1'b0, 10'h018, 10'h000);
        check(line_build_out, 6'h00, "unused build-out code");
        // Timeout on at the longest setting, so no loop expires here
        opt_write(1'b1, 1'b0, 10'h380, 10'h000);
        foreach (loops[i]) begin
            loop_cmd(loops[i][19:11]);
            check({loop_timer_running, facility_transmit_select, customer_transmit_select, facility_indicator,
                customer_indicator, loopback_indicator}, loops[i][10:0], "loop state");
        end
        foreach (mons[i]) begin
            opt_write(1'b1, 1'b0, mons[i][17:8], 10'h000);
            seen = 7'h00;
            mon = 7'h01 << mons[i][7:5];
            @(negedge clk);
            mon = 7'h00;
            repeat (3) @(negedge clk);
            check({facility_transmit_select, customer_transmit_select, seen[4:0]}, {TX_THRU, TX_THRU, mons[i][4:0]},
                "monitor event");
        end
        seen = 7'h00;
        u_dpm_line_model.dropout(0, 140 * TICK);
        u_dpm_line_model.dropout(1, 140 * TICK);
        repeat (10) @(negedge clk);
        check(seen[6:5], 2'b00, "short dropouts");
        u_dpm_line_model.set_low(0, 1'b1);
        wait_los(0);
        check({facility_indicator, customer_transmit_select}, {LED_RED, TX_AIS}, "facility loss");
        u_dpm_line_model.set_low(0, 1'b0);
        repeat (6) @(negedge clk);
        check({facility_los, facility_indicator, customer_transmit_select}, {1'b0, LED_GREEN, TX_THRU},
            "facility recovered");
        u_dpm_line_model.set_low(1, 1'b1);
        wait_los(1);
        check({customer_indicator, facility_indicator}, {LED_RED, LED_GREEN}, "customer loss");
        u_dpm_line_model.set_low(1, 1'b0);
        repeat (6) @(negedge clk);
        check({customer_los, customer_indicator}, {1'b0, LED_GREEN}, "customer recovered");
        // Second reset in mid-run, with a loop and options active
        opt_write(1'b1, 1'b0, 10'h00f, 10'h000);
        loop_cmd(9'h040);
        reset_n = 1'b0;
        @(negedge clk);
        check({loopback_indicator, facility_transmit_select, downstream_regeneration, line_build_out}, 16'h0000,
            "outputs in mid-run reset");
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        check({loopback_indicator, facility_indicator, upstream_regeneration, line_build_out},
            {LED_OFF, LED_GREEN, 7'h00}, "state cleared by reset");
        close_out();
    end
endmodule
`default_nettype wire
